/* File: hdl/tester_pkg.sv */
// Constants, carriers and state layout of the serial-to-AXI memory tester
// Function
// - Single request issues one AXI transaction of one beat, eight bytes.
// - Single write takes 32-bit address, 64-bit word and writes it there.
// - Single read takes 32-bit address and returns the 64-bit word.
// - Burst transactions use sixteen beats, 128 bytes each.
// - A burst request runs sixteen 16-beat transactions, 2048 bytes.
// - Burst write takes start address and first word; bridge makes the rest.
// - Each following burst-write word is previous plus one; 256 words.
// - Burst read returns 2048 bytes from consecutive locations.
// - Serial link runs at fixed 115200 baud.
// - AXI master takes operation, lengths, address, data and drives controller.
// - Read data is buffered in RAM; sent only after all bursts finish.
// - Read buffer holds 256 words of 64 bits, sent as 2048 bytes.
package tester_pkg;
	localparam int CLK_HZ      = 40_000_000;
	localparam int BAUD_RATE   = 115_200;
	localparam int BIT_CYCLES  = CLK_HZ / BAUD_RATE;
	localparam int HALF_CYCLES = BIT_CYCLES / 2;
	localparam int BAUD_W      = $clog2(BIT_CYCLES);
	localparam int ADDR_W      = 32;
	localparam int DATA_W      = 64;
	localparam int ADDR_BYTES  = 4;
	localparam int WORD_BYTES  = 8;
	localparam int BURST_BEATS = 16;
	localparam int BURST_COUNT = 16;
	localparam int BURST_WORDS = 256;
	localparam int BURST_BYTES = 2048;
	localparam int BURST_SHIFT = 7;
	localparam logic [7:0] AXI_LEN_SINGLE = 8'h00;
	localparam logic [7:0] AXI_LEN_BURST  = 8'h0f;
	localparam logic [2:0] AXI_SIZE_8B    = 3'h3;
	localparam logic [1:0] AXI_BURST_INCR = 2'h1;
	localparam logic [7:0] OP_SINGLE_WR   = 8'h01;
	localparam logic [7:0] OP_SINGLE_RD   = 8'h02;
	localparam logic [7:0] OP_BURST_WR    = 8'h03;
	localparam logic [7:0] OP_BURST_RD    = 8'h04;
	localparam logic [7:0] WRITE_ACK      = 8'h5a;

	typedef enum logic [3:0] {
		ST_CMD, ST_ADDR, ST_DATA, ST_WADDR, ST_WDATA, ST_WRESP,
		ST_RADDR, ST_RDATA, ST_SEND, ST_DRAIN
	} bridge_state_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        len;
		logic [2:0]        size;
		logic [1:0]        burst;
	} axi_addr_s;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [7:0]        strb;
		logic              last;
	} axi_wdata_s;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [1:0]        resp;
		logic              last;
	} axi_rdata_s;

	typedef struct packed {
		bridge_state_e     state;
		logic              isWrite;
		logic              isBurst;
		logic [ADDR_W-1:0] baseAddr;
		logic [DATA_W-1:0] startData;
		logic [DATA_W-1:0] curData;
		logic [4:0]        burstCnt;
		logic [3:0]        beatCnt;
		logic [8:0]        wordCnt;
		logic [11:0]       byteCnt;
		logic [3:0]        fieldCnt;
		logic              txd;
		logic              txBusy;
		logic [BAUD_W-1:0] txBaud;
		logic [3:0]        txBit;
		logic [8:0]        txShift;
		logic              rxBusy;
		logic [BAUD_W-1:0] rxBaud;
		logic [3:0]        rxBit;
		logic [7:0]        rxShift;
		logic              rxValid;
		logic [7:0]        rxData;
	} bridge_regs_s;
endpackage

/* File: hdl/byte_skid_buffer.sv */
// Two-entry valid/ready buffer between byte source and serial transmitter
`timescale 1ns/10ps
module byte_skid_buffer #(
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             srst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	typedef struct packed {
		logic [1:0]       count;
		logic [WIDTH-1:0] slot0;
		logic [WIDTH-1:0] slot1;
	} skid_regs_s;

	skid_regs_s bufReg;
	skid_regs_s bufNext;
	logic       push;
	logic       pop;

	assign inReady  = (bufReg.count != 2'h2);
	assign outValid = (bufReg.count != 2'h0);
	assign outData  = bufReg.slot0;
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_comb begin
		bufNext = bufReg;
		case ({push, pop})
			2'b10: begin
				if (bufReg.count == 2'h0) begin
					bufNext.slot0 = inData;
				end else begin
					bufNext.slot1 = inData;
				end
				bufNext.count = bufReg.count + 2'h1;
			end
			2'b01: begin
				bufNext.slot0 = bufReg.slot1;
				bufNext.count = bufReg.count - 2'h1;
			end
			2'b11: begin
				// Count stays; head moves on and the new word takes its place
				if (bufReg.count == 2'h1) begin
					bufNext.slot0 = inData;
				end else begin
					bufNext.slot0 = bufReg.slot1;
					bufNext.slot1 = inData;
				end
			end
			default: begin
				bufNext = bufReg;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			bufReg <= '0;
		end else begin
			bufReg <= bufNext;
		end
	end

	COV_BUFFER_FULL: cover property (@(posedge ref_clk) disable iff (srst)
		bufReg.count == 2'h2 && !outReady);
endmodule

/* File: hdl/serial_to_axi_memory_tester.sv */
// Serial command front end and AXI master for the memory tester bridge
`timescale 1ns/10ps
module serial_to_axi_memory_tester
	import tester_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic srst,
	input  wire logic serialIn,
	output logic      serialOut,
	output logic      awValid,
	input  wire logic awReady,
	output axi_addr_s awBus,
	output logic      wValid,
	input  wire logic wReady,
	output axi_wdata_s wBus,
	input  wire logic bValid,
	output logic      bReady,
	input  wire logic [1:0] bResp,
	output logic      arValid,
	input  wire logic arReady,
	output axi_addr_s arBus,
	input  wire logic rValid,
	output logic      rReady,
	input  wire axi_rdata_s rBus
);
	bridge_regs_s      stateReg;
	bridge_regs_s      stateNext;
	logic [DATA_W-1:0] readBuf [BURST_WORDS];
	logic [DATA_W-1:0] ramWord;
	logic [7:0]        ramByte;
	logic              ramWe;
	logic              lastBeat;
	logic              moreBursts;
	logic [11:0]       sendLast;
	logic              bufInValid;
	logic              bufInReady;
	logic [7:0]        bufInByte;
	logic              bufOutValid;
	logic [7:0]        bufOutByte;
	logic [7:0]        opByte;
	logic [ADDR_W-1:0] txnAddr;

	assign serialOut = stateReg.txd;
	assign opByte    = stateReg.rxData;
	assign lastBeat  = !stateReg.isBurst || (stateReg.beatCnt == 4'(BURST_BEATS - 1));
	assign moreBursts = stateReg.isBurst && (stateReg.burstCnt != 5'(BURST_COUNT - 1));
	assign txnAddr = stateReg.baseAddr + (ADDR_W'(stateReg.burstCnt[3:0]) << BURST_SHIFT);
	// Words go out most significant byte first
	assign ramWord = readBuf[stateReg.byteCnt[10:3]];
	assign ramByte = ramWord[8 * (7 - 32'(stateReg.byteCnt[2:0])) +: 8];
	assign sendLast = stateReg.isWrite ? 12'h000 :
		(stateReg.isBurst ? 12'(BURST_BYTES - 1) : 12'(WORD_BYTES - 1));

	// AXI carriers are built from registers: addr adds the burst offset, len and last are decoded too
	always_comb begin
		awBus.addr  = txnAddr;
		awBus.len   = stateReg.isBurst ? AXI_LEN_BURST : AXI_LEN_SINGLE;
		awBus.size  = AXI_SIZE_8B;
		awBus.burst = AXI_BURST_INCR;
		arBus       = awBus;
		wBus.data   = stateReg.curData;
		wBus.strb   = 8'hff;
		wBus.last   = lastBeat;
	end

	always_comb begin
		stateNext = stateReg;
		stateNext.rxValid = 1'b0;
		ramWe      = 1'b0;
		bufInValid = 1'b0;
		bufInByte  = WRITE_ACK;
		awValid    = 1'b0;
		wValid     = 1'b0;
		bReady     = 1'b0;
		arValid    = 1'b0;
		rReady     = 1'b0;

		// Receiver, centre sampled; a bad stop bit drops the byte
		if (!stateReg.rxBusy) begin
			if (!serialIn) begin
				stateNext.rxBusy = 1'b1;
				stateNext.rxBaud = BAUD_W'(HALF_CYCLES);
				stateNext.rxBit  = 4'h0;
			end
		end else if (stateReg.rxBaud != '0) begin
			stateNext.rxBaud = stateReg.rxBaud - 1'b1;
		end else begin
			stateNext.rxBaud = BAUD_W'(BIT_CYCLES - 1);
			stateNext.rxBit  = stateReg.rxBit + 4'h1;
			if (stateReg.rxBit == 4'h0 && serialIn) begin
				stateNext.rxBusy = 1'b0;
			end else if (stateReg.rxBit == 4'h9) begin
				stateNext.rxBusy  = 1'b0;
				stateNext.rxValid = serialIn;
				stateNext.rxData  = stateReg.rxShift;
			end else if (stateReg.rxBit != 4'h0) begin
				stateNext.rxShift = {serialIn, stateReg.rxShift[7:1]};
			end
		end

		// Transmitter, fed by the skid buffer
		if (!stateReg.txBusy) begin
			if (bufOutValid) begin
				stateNext.txBusy  = 1'b1;
				stateNext.txShift = {1'b1, bufOutByte};
				stateNext.txd     = 1'b0;
				stateNext.txBaud  = BAUD_W'(BIT_CYCLES - 1);
				stateNext.txBit   = 4'h0;
			end
		end else if (stateReg.txBaud != '0) begin
			stateNext.txBaud = stateReg.txBaud - 1'b1;
		end else if (stateReg.txBit == 4'h9) begin
			stateNext.txBusy = 1'b0;
		end else begin
			stateNext.txd     = stateReg.txShift[0];
			stateNext.txShift = {1'b1, stateReg.txShift[8:1]};
			stateNext.txBit   = stateReg.txBit + 4'h1;
			stateNext.txBaud  = BAUD_W'(BIT_CYCLES - 1);
		end

		case (stateReg.state)
			// Bytes arriving outside ST_CMD, ST_ADDR and ST_DATA are dropped on purpose
			ST_CMD: begin
				if (stateReg.rxValid) begin
					stateNext.isWrite  = (opByte == OP_SINGLE_WR) || (opByte == OP_BURST_WR);
					stateNext.isBurst  = (opByte == OP_BURST_WR) || (opByte == OP_BURST_RD);
					stateNext.fieldCnt = 4'h0;
					stateNext.burstCnt = 5'h00;
					stateNext.wordCnt  = 9'h000;
					stateNext.byteCnt  = 12'h000;
					if (opByte == OP_SINGLE_WR || opByte == OP_SINGLE_RD ||
						opByte == OP_BURST_WR || opByte == OP_BURST_RD) begin
						stateNext.state = ST_ADDR;
					end
				end
			end
			ST_ADDR: begin
				if (stateReg.rxValid) begin
					stateNext.baseAddr = {stateReg.baseAddr[23:0], opByte};
					stateNext.fieldCnt = stateReg.fieldCnt + 4'h1;
					if (stateReg.fieldCnt == 4'(ADDR_BYTES - 1)) begin
						stateNext.fieldCnt = 4'h0;
						stateNext.state = stateReg.isWrite ? ST_DATA : ST_RADDR;
					end
				end
			end
			ST_DATA: begin
				if (stateReg.rxValid) begin
					stateNext.curData  = {stateReg.curData[55:0], opByte};
					stateNext.startData = stateNext.curData;
					stateNext.fieldCnt = stateReg.fieldCnt + 4'h1;
					if (stateReg.fieldCnt == 4'(WORD_BYTES - 1)) begin
						stateNext.state = ST_WADDR;
					end
				end
			end
			ST_WADDR: begin
				awValid = 1'b1;
				stateNext.beatCnt = 4'h0;
				if (awReady) begin
					stateNext.state = ST_WDATA;
				end
			end
			ST_WDATA: begin
				wValid = 1'b1;
				if (wReady) begin
					stateNext.curData = stateReg.curData + 64'h0000_0000_0000_0001;
					stateNext.wordCnt = stateReg.wordCnt + 9'h001;
					stateNext.beatCnt = stateReg.beatCnt + 4'h1;
					if (lastBeat) begin
						stateNext.state = ST_WRESP;
					end
				end
			end
			ST_WRESP: begin
				bReady = 1'b1;
				if (bValid) begin
					stateNext.burstCnt = stateReg.burstCnt + 5'h01;
					stateNext.state = moreBursts ? ST_WADDR : ST_SEND;
				end
			end
			ST_RADDR: begin
				arValid = 1'b1;
				stateNext.beatCnt = 4'h0;
				if (arReady) begin
					stateNext.state = ST_RDATA;
				end
			end
			ST_RDATA: begin
				rReady = 1'b1;
				if (rValid) begin
					ramWe = 1'b1;
					stateNext.wordCnt = stateReg.wordCnt + 9'h001;
					stateNext.beatCnt = stateReg.beatCnt + 4'h1;
					if (lastBeat) begin
						stateNext.burstCnt = stateReg.burstCnt + 5'h01;
						stateNext.state = moreBursts ? ST_RADDR : ST_SEND;
					end
				end
			end
			ST_SEND: begin
				bufInValid = 1'b1;
				bufInByte  = stateReg.isWrite ? WRITE_ACK : ramByte;
				if (bufInReady) begin
					stateNext.byteCnt = stateReg.byteCnt + 12'h001;
					if (stateReg.byteCnt == sendLast) begin
						stateNext.state = ST_DRAIN;
					end
				end
			end
			ST_DRAIN: begin
				// Wait for the last stop bit so the host never overlaps replies
				if (!bufOutValid && !stateReg.txBusy) begin
					stateNext.state = ST_CMD;
				end
			end
			default: begin
				stateNext.state = ST_CMD;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			stateReg     <= '0;
			stateReg.txd <= 1'b1;
		end else begin
			stateReg <= stateNext;
		end
	end

	// Error responses are not reported; data is stored as it came
	always_ff @(posedge ref_clk) begin
		if (ramWe) begin
			readBuf[stateReg.wordCnt[7:0]] <= rBus.data;
		end
	end

	byte_skid_buffer #(
		.WIDTH(8)
	) txBuffer (
		.ref_clk (ref_clk),
		.srst    (srst),
		.inValid (bufInValid),
		.inReady (bufInReady),
		.inData  (bufInByte),
		.outValid(bufOutValid),
		.outReady(!stateReg.txBusy),
		.outData (bufOutByte)
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	AST_SINGLE_ONE_BEAT:
	assert property ((awValid || arValid) && !stateReg.isBurst |->
		awBus.len == AXI_LEN_SINGLE && arBus.len == AXI_LEN_SINGLE && awBus.size == AXI_SIZE_8B)
		else $error("single op is not one 8-byte beat");
	AST_SINGLE_WRITE_DATA:
	assert property (wValid && !stateReg.isBurst |-> wBus.data == stateReg.startData && wBus.last)
		else $error("single write data differs from host word");
	AST_SINGLE_READ_RETURN:
	assert property (stateReg.state == ST_SEND && !stateReg.isWrite && !stateReg.isBurst &&
		stateReg.byteCnt == 12'h000 |-> bufInByte == readBuf[0][63:56])
		else $error("single read returns wrong first byte");
	AST_BURST_SIXTEEN:
	assert property ((awValid || arValid) && stateReg.isBurst |->
		awBus.len == AXI_LEN_BURST && arBus.len == AXI_LEN_BURST)
		else $error("burst transaction is not sixteen beats");
	AST_BURST_WORD_TOTAL:
	assert property (stateReg.state == ST_WRESP && bValid && stateReg.isBurst &&
		!moreBursts |-> stateReg.wordCnt == 9'(BURST_WORDS))
		else $error("burst write did not move 256 words");
	AST_WRITE_INCREMENT:
	assert property (wValid && wReady |=> $past(wBus.data) + 64'h0000_0000_0000_0001 ==
		stateReg.curData && stateReg.curData == stateReg.startData + 64'(stateReg.wordCnt))
		else $error("write data not previous plus one");
	AST_BURST_READ_BYTES:
	assert property ($rose(stateReg.state == ST_DRAIN) && !stateReg.isWrite &&
		stateReg.isBurst |-> stateReg.byteCnt == 12'(BURST_BYTES))
		else $error("burst read did not return 2048 bytes");
	AST_BIT_TIME:
	assert property ($changed(serialOut) |-> $past(stateReg.txBaud) == '0)
		else $error("serial output changed inside a bit time");
	AST_SEND_AFTER_READ:
	assert property (stateReg.state == ST_SEND && !stateReg.isWrite |->
		stateReg.wordCnt == (stateReg.isBurst ? 9'(BURST_WORDS) : 9'h001))
		else $error("reply started before all read data stored");
	AST_ADDR_STEP:
	assert property (awValid && awReady && moreBursts |->
		##[1:40] awValid && awBus.addr == $past(awBus.addr) + 32'h0000_0080)
		else $error("next transaction not 128 bytes on");
	AST_IDLE_AFTER_DRAIN:
	assert property (stateReg.state == ST_CMD && $past(stateReg.state) != ST_CMD |->
		$past(stateReg.state) == ST_DRAIN)
		else $error("command accepted before completion");

	COV_SINGLE_WRITE: cover property (stateReg.state == ST_WRESP && bValid && !stateReg.isBurst);
	COV_BURST_WRITE: cover property (stateReg.state == ST_WRESP && bValid && !moreBursts &&
		stateReg.isBurst);
	COV_BURST_READ: cover property (stateReg.state == ST_DRAIN && stateReg.isBurst &&
		!stateReg.isWrite);
	COV_SINGLE_READ: cover property (stateReg.state == ST_DRAIN && !stateReg.isBurst &&
		!stateReg.isWrite);
endmodule

/* File: dv/host_uart_model.sv */
// Host-side serial model: sends command bytes, collects reply bytes
`timescale 1ns/10ps
module host_uart_model
	import tester_pkg::*;
(
	input  wire logic ref_clk,
	output logic      hostTx,
	input  wire logic hostRx
);
	localparam int WAIT_MAX = 60000;

	initial hostTx = 1'b1;

	// Frame is start, eight data bits LSB first, stop
	task automatic put_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge ref_clk);
			hostTx = f[i];
			repeat (BIT_CYCLES - 1) @(negedge ref_clk);
		end
	endtask

	// Bounded wait; ok stays low on timeout or a bad stop bit
	task automatic get_byte(output logic [7:0] b, output bit ok);
		int n;
		n = 0;
		ok = 1'b0;
		b = 8'h00;
		while (hostRx !== 1'b0 && n < WAIT_MAX) begin
			@(negedge ref_clk);
			n++;
		end
		if (n == WAIT_MAX)
			return;
		repeat (HALF_CYCLES) @(negedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(negedge ref_clk);
			b[i] = hostRx;
		end
		repeat (BIT_CYCLES) @(negedge ref_clk);
		ok = (hostRx === 1'b1);
	endtask
endmodule

/* File: dv/serial_to_axi_memory_tester_tb.sv */
// Testbench: host commands in, AXI memory responder, reply checks
`timescale 1ns/10ps
module serial_to_axi_memory_tester_tb
	import tester_pkg::*;
();
	localparam logic [ADDR_W-1:0] SGL_ADDR = 32'h03FF_FFF8;
	localparam logic [ADDR_W-1:0] BST_ADDR = 32'h03FF_F7F8;
	localparam logic [DATA_W-1:0] SGL_DATA = 64'hA5C3_0F1E_7B96_2D48;
	// Start near the top so the increment carries through many bits
	localparam logic [DATA_W-1:0] BST_DATA = 64'h7FFF_FFFF_FFFF_FFF0;

	logic       ref_clk = 1'b0;
	logic       srst;
	logic       serialIn;
	logic       serialOut;
	logic       awValid, awReady, wValid, wReady, bValid, bReady;
	logic       arValid, arReady, rValid, rReady;
	logic [1:0] bResp;
	axi_addr_s  awBus, arBus;
	axi_wdata_s wBus;
	axi_rdata_s rBus;
	bit         slow;
	int         n_fail;
	int         comparisons;
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
	axi_addr_s  awLog[$];
	axi_addr_s  arLog[$];
	axi_wdata_s wLog[$];

	always #12.5 ref_clk = ~ref_clk;

	host_uart_model i_host (.ref_clk(ref_clk), .hostTx(serialIn), .hostRx(serialOut));

	serial_to_axi_memory_tester i_dut (
		.ref_clk(ref_clk), .srst(srst), .serialIn(serialIn), .serialOut(serialOut),
		.awValid(awValid), .awReady(awReady), .awBus(awBus),
		.wValid(wValid), .wReady(wReady), .wBus(wBus),
		.bValid(bValid), .bReady(bReady), .bResp(bResp),
		.arValid(arValid), .arReady(arReady), .arBus(arBus),
		.rValid(rValid), .rReady(rReady), .rBus(rBus)
	);

	// Write side of the memory; slow mode stalls address and every beat
	// Settled outputs are read at the falling edge, never in the launching step
	initial begin : axi_wr
		axi_addr_s a;
		awReady = 1'b0;
		wReady  = 1'b0;
		bValid  = 1'b0;
		bResp   = 2'h0;
		forever begin
			@(negedge ref_clk);
			if (awValid === 1'b1) begin
				a = awBus;
				awLog.push_back(a);
				if (slow)
					@(negedge ref_clk);
				awReady = 1'b1;
				@(negedge ref_clk);
				awReady = 1'b0;
				for (int k = 0; k <= int'(a.len); k++) begin
					if (slow)
						@(negedge ref_clk);
					wReady = 1'b1;
					for (int t = 0; t < 100 && wValid !== 1'b1; t++)
						@(negedge ref_clk);
					if (wValid !== 1'b1)
						n_fail++;
					wLog.push_back(wBus);
					mem[a.addr + 32'(k * WORD_BYTES)] = wBus.data;
					// Beat is taken at the rising edge inside this wait
					@(negedge ref_clk);
					if (slow || k == int'(a.len))
						wReady = 1'b0;
				end
				bValid = 1'b1;
				for (int t = 0; t < 100 && bReady !== 1'b1; t++)
					@(negedge ref_clk);
				if (bReady !== 1'b1)
					n_fail++;
				@(negedge ref_clk);
				bValid = 1'b0;
			end
		end
	end

	// Read side; idle data shows the inverse of the last beat
	initial begin : axi_rd
		axi_addr_s a;
		arReady = 1'b0;
		rValid = 1'b0;
		rBus = '0;
		forever begin
			@(negedge ref_clk);
			if (arValid === 1'b1) begin
				a = arBus;
				arLog.push_back(a);
				if (slow)
					@(negedge ref_clk);
				arReady = 1'b1;
				@(negedge ref_clk);
				arReady = 1'b0;
				for (int k = 0; k <= int'(a.len); k++) begin
					rValid = 1'b1;
					rBus   = {mem[a.addr + 32'(k * WORD_BYTES)], 2'h0, k == int'(a.len)};
					for (int t = 0; t < 100 && rReady !== 1'b1; t++)
						@(negedge ref_clk);
					if (rReady !== 1'b1)
						n_fail++;
					@(negedge ref_clk);
				end
				rValid    = 1'b0;
				rBus.data = ~rBus.data;
			end
		end
	end

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk_val(input string nm, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_addr(input string nm, input axi_addr_s e, input axi_addr_s g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Sends one command while collecting nRep reply bytes, each shifted in at the bottom
	task automatic run_cmd(input logic [7:0] op, input logic [ADDR_W-1:0] a,
			input logic [DATA_W-1:0] d, input int nRep, output logic [DATA_W-1:0] rep);
		logic [7:0] q[$];
		logic [7:0] b;
		bit         ok;
		q = {op, a[31:24], a[23:16], a[15:8], a[7:0]};
		if (op == OP_SINGLE_WR || op == OP_BURST_WR)
			for (int i = 7; i >= 0; i--)
				q.push_back(d[8 * i +: 8]);
		rep = '0;
		awLog.delete();
		wLog.delete();
		arLog.delete();
		// Let the previous reply's stop bit end before the next opcode
		repeat (BIT_CYCLES) @(negedge ref_clk);
		fork
			foreach (q[i]) i_host.put_byte(q[i]);
			for (int k = 0; k < nRep; k++) begin
				i_host.get_byte(b, ok);
				if (!ok) begin
					n_fail++;
					end_sim();
				end
				rep = {rep[55:0], b};
			end
		join
	endtask

	task automatic sc_single_write();
		logic [DATA_W-1:0] rep;
		slow = 1'b0;
		run_cmd(OP_SINGLE_WR, SGL_ADDR, SGL_DATA, 1, rep);
		chk_val("write ack", {56'h0, WRITE_ACK}, rep);
		chk_val("aw count", 64'(awLog.size()), 64'h1);
		chk_addr("aw", {SGL_ADDR, AXI_LEN_SINGLE, AXI_SIZE_8B, AXI_BURST_INCR}, awLog[0]);
		chk_val("w count", 64'(wLog.size()), 64'h1);
		chk_val("w data", SGL_DATA, wLog[0].data);
		chk_val("w strb", 64'h00FF, {56'h0, wLog[0].strb});
		chk_val("w last", 64'h1, {63'h0, wLog[0].last});
	endtask

	// Stalling memory; addresses, lengths, data and last over all beats
	task automatic sc_burst_write();
		logic [DATA_W-1:0] rep;
		slow = 1'b1;
		run_cmd(OP_BURST_WR, BST_ADDR, BST_DATA, 1, rep);
		chk_val("burst ack", {56'h0, WRITE_ACK}, rep);
		chk_val("aw count", 64'(awLog.size()), 64'(BURST_COUNT));
		chk_val("w count", 64'(wLog.size()), 64'(BURST_WORDS));
		for (int k = 0; k < BURST_COUNT; k++)
			chk_addr("burst aw", {BST_ADDR + 32'(k * WORD_BYTES * BURST_BEATS), AXI_LEN_BURST,
				AXI_SIZE_8B, AXI_BURST_INCR}, awLog[k]);
		for (int i = 0; i < BURST_WORDS; i++) begin
			chk_val("burst data", BST_DATA + 64'(i), wLog[i].data);
			chk_val("burst last", 64'(i % BURST_BEATS == BURST_BEATS - 1),
				{63'h0, wLog[i].last});
		end
	endtask

	// Reads back the single word; the burst ended just below it untouched
	task automatic sc_single_read();
		logic [DATA_W-1:0] rep;
		slow = 1'b1;
		run_cmd(OP_SINGLE_RD, SGL_ADDR, 64'h0, WORD_BYTES, rep);
		chk_addr("ar", {SGL_ADDR, AXI_LEN_SINGLE, AXI_SIZE_8B, AXI_BURST_INCR}, arLog[0]);
		chk_val("ar count", 64'(arLog.size()), 64'h1);
		chk_val("read word", SGL_DATA, rep);
	endtask

	// Full reply is too long to wait for; reset cuts it after the first byte
	task automatic sc_burst_read_reset();
		logic [DATA_W-1:0] rep;
		slow = 1'b0;
		run_cmd(OP_BURST_RD, BST_ADDR, 64'h0, 1, rep);
		chk_val("burst read byte", {56'h0, BST_DATA[63:56]}, rep);
		chk_val("ar count", 64'(BURST_COUNT), 64'(arLog.size()));
		for (int k = 0; k < BURST_COUNT; k++)
			chk_addr("burst ar", {BST_ADDR + 32'(k * WORD_BYTES * BURST_BEATS), AXI_LEN_BURST,
				AXI_SIZE_8B, AXI_BURST_INCR}, arLog[k]);
		srst = 1'b1;
		repeat (6) @(negedge ref_clk);
		srst = 1'b0;
		chk_val("line idle", 64'h1, {63'h0, serialOut});
	endtask

	initial begin
		srst = 1'b1;
		slow = 1'b0;
		n_fail = 0;
		comparisons = 0;
		repeat (6) @(negedge ref_clk);
		srst = 1'b0;
		sc_single_write();
		sc_burst_write();
		sc_burst_read_reset();
		sc_single_read();
		end_sim();
	end
endmodule
